// ===== logic/emp_port.sv
// external memory port: address/data pins, strobes, arbitration, mode pins
// assumes core requests and mode writes come from logic on clk_sys
`timescale 1ns/1ps
module emp_port #(
   parameter int WAIT_MIN = emp_pkg::WAIT_MIN_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire emp_pkg::emp_req_type core_req,
   input wire logic insn_done,
   input wire logic mode_we,
   input wire logic [7:0] mode_wdata,
   input wire logic [1:0] irq_edge_mode,
   input wire logic [1:0] irq_ack,
   input wire logic [emp_pkg::DATA_W-1:0] data_in,
   input wire logic bus_request_n,
   input wire logic boot_mode_pin_a,
   input wire logic boot_mode_pin_b,
   output emp_pkg::emp_pins_type pins_q,
   output logic core_ack_q,
   output logic [emp_pkg::DATA_W-1:0] core_rdata_q,
   output logic [7:0] operating_mode_register_q,
   output logic external_request_a_q,
   output logic external_request_b_q
);
   // whole port state
   typedef struct packed {
      emp_pkg::emp_state_type state;
      emp_pkg::emp_pins_type pins;
      logic ack;
      logic [emp_pkg::DATA_W-1:0] rdata;
      logic [7:0] mode;
      logic strap_pend;
      logic strap_wait; // pin modules latch the strap one edge after release
      logic [7:0] cnt;
      logic req_s1;
      logic req_s2;
   } emp_port_type;
   emp_port_type st_q, st_d;

   logic strap_a, strap_b; // latched boot levels
   logic irq_a, irq_b; // pending interrupts

   // pin a: strap plus request a
   emp_irq_input u_pin_a (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin_n(boot_mode_pin_a),
      .edge_mode(irq_edge_mode[0]),
      .irq_ack(irq_ack[0]),
      .strap_q(strap_a),
      .irq_q(irq_a)
   );

   // pin b: strap plus request b
   emp_irq_input u_pin_b (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin_n(boot_mode_pin_b),
      .edge_mode(irq_edge_mode[1]),
      .irq_ack(irq_ack[1]),
      .strap_q(strap_b),
      .irq_q(irq_b)
   );

   logic arb_wait; // bit set selects wait/strobe use of the shared pins
   logic req_low; // synchronised request or wait level
   assign arb_wait = st_q.mode[emp_pkg::ARB_BIT];
   assign req_low = !st_q.req_s2;

   // next state
   always_comb begin
      st_d = st_q;
      st_d.req_s1 = bus_request_n;
      st_d.req_s2 = st_q.req_s1;
      st_d.ack = 1'b0;
      // strap comes out of the pin module one edge after release
      if (st_q.strap_wait) begin
         // strap not yet latched in the pin modules, skip this edge
         st_d.strap_wait = 1'b0;
      end else if (st_q.strap_pend) begin
         st_d.mode[1:0] = {strap_b, strap_a};
         st_d.strap_pend = 1'b0;
      end else if (mode_we) begin
         st_d.mode = mode_wdata;
      end
      case (st_q.state)
         emp_pkg::EMP_IDLE: begin
            // outputs driven except data, strobes idle, address keeps last value
            st_d.pins.ctrl_oe = 1'b1;
            st_d.pins.addr_oe = 1'b1;
            st_d.pins.grant_strobe_oe = 1'b1;
            st_d.pins.grant_strobe_n = 1'b1;
            st_d.pins.data_oe = 1'b0;
            st_d.pins.program_space_select_n = 1'b1;
            st_d.pins.data_space_select_n = 1'b1;
            st_d.pins.read_n = 1'b1;
            st_d.pins.write_n = 1'b1;
            if (!arb_wait && req_low && insn_done) begin
               // release address, data and control pins at instruction end; grant pin stays driven
               st_d.pins.ctrl_oe = 1'b0;
               st_d.pins.addr_oe = 1'b0;
               st_d.pins.data_oe = 1'b0;
               st_d.state = emp_pkg::EMP_RELEASED;
            end else if (core_req.valid) begin
               st_d.pins.addr = core_req.addr; // address moves only here
               st_d.pins.data = core_req.wdata;
               st_d.pins.data_oe = core_req.write;
               st_d.pins.program_space_select_n =
                  !(core_req.space == emp_pkg::SPACE_P);
               st_d.pins.data_space_select_n =
                  (core_req.space == emp_pkg::SPACE_P);
               st_d.pins.xy_select = (core_req.space == emp_pkg::SPACE_X);
               st_d.pins.read_n = core_req.write;
               st_d.pins.write_n = !core_req.write;
               st_d.pins.grant_strobe_n = !arb_wait; // strobe marks access
               st_d.cnt = 8'(WAIT_MIN);
               st_d.state = emp_pkg::EMP_ACCESS;
            end
         end
         emp_pkg::EMP_ACCESS: begin
            // hold strobes until minimum width done and wait pin high
            if (st_q.cnt > 8'h01) begin
               st_d.cnt = st_q.cnt - 8'h01;
            end else if (!(arb_wait && req_low)) begin
               st_d.ack = 1'b1;
               st_d.rdata = data_in;
               st_d.pins.read_n = 1'b1;
               st_d.pins.write_n = 1'b1;
               st_d.pins.program_space_select_n = 1'b1;
               st_d.pins.data_space_select_n = 1'b1;
               st_d.pins.grant_strobe_n = 1'b1;
               st_d.pins.data_oe = 1'b0;
               st_d.state = emp_pkg::EMP_IDLE;
            end
         end
         emp_pkg::EMP_RELEASED: begin
            // grant asserted only now that the port floats
            st_d.pins.grant_strobe_n = 1'b0;
            st_d.pins.data_oe = 1'b0;
            if (!req_low || arb_wait) begin
               st_d.pins.grant_strobe_n = 1'b1;
               st_d.pins.ctrl_oe = 1'b1;
               st_d.pins.addr_oe = 1'b1;
               st_d.state = emp_pkg::EMP_IDLE;
            end
         end
         default: st_d.state = emp_pkg::EMP_IDLE;
      endcase
   end

   // registers; reset floats control and grant pins
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q.state <= emp_pkg::EMP_IDLE;
         st_q.pins <= '0;
         st_q.pins.ctrl_oe <= 1'b0;
         st_q.pins.grant_strobe_oe <= 1'b0;
         st_q.pins.program_space_select_n <= 1'b1;
         st_q.pins.data_space_select_n <= 1'b1;
         st_q.pins.read_n <= 1'b1;
         st_q.pins.write_n <= 1'b1;
         st_q.pins.grant_strobe_n <= 1'b1;
         st_q.ack <= 1'b0;
         st_q.rdata <= '0;
         st_q.mode <= emp_pkg::MODE_RST;
         st_q.strap_pend <= 1'b1;
         st_q.strap_wait <= 1'b1;
         st_q.cnt <= 8'h00;
         st_q.req_s1 <= 1'b1;
         st_q.req_s2 <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from flip-flops
   assign pins_q = st_q.pins;
   assign core_ack_q = st_q.ack;
   assign core_rdata_q = st_q.rdata;
   assign operating_mode_register_q = st_q.mode;
   assign external_request_a_q = irq_a;
   assign external_request_b_q = irq_b;
endmodule

// ===== logic/emp_pkg.sv
// package for the external memory port control block
// assumes one 40 MHz clock domain and a synchronous active-high reset
package emp_pkg;
   localparam int ADDR_W = 16; // external address width
   localparam int DATA_W = 24; // external data width
   localparam int ARB_BIT = 7; // mode word bit choosing wait/strobe over request/grant
   localparam logic [7:0] MODE_RST = 8'h00; // mode word value after reset
   localparam int WAIT_MIN_NS = 25; // least strobe width in ns
   localparam int CLK_NS = 25; // clock period in ns
   localparam int WAIT_MIN_CYC = (WAIT_MIN_NS + CLK_NS - 1) / CLK_NS; // rounded up
   localparam logic [1:0] SPACE_P = 2'h0; // program space
   localparam logic [1:0] SPACE_X = 2'h1; // x data space
   localparam logic [1:0] SPACE_Y = 2'h2; // y data space

   // port states
   typedef enum logic [1:0] {EMP_IDLE, EMP_ACCESS, EMP_RELEASED} emp_state_type;

   // one core access request
   typedef struct packed {
      logic valid;
      logic write;
      logic [1:0] space;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } emp_req_type;

   // pin outputs with their enables
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic addr_oe;
      logic [DATA_W-1:0] data;
      logic data_oe;
      logic program_space_select_n;
      logic data_space_select_n;
      logic xy_select;
      logic read_n;
      logic write_n;
      logic ctrl_oe;
      logic grant_strobe_n;
      logic grant_strobe_oe;
   } emp_pins_type;
endpackage

// ===== logic/emp_irq_input.sv
// one mode/interrupt pin: synchroniser, strap latch and interrupt detector
// assumes the pin is asynchronous to clk_sys
`timescale 1ns/1ps
module emp_irq_input (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic pin_n,
   input wire logic edge_mode,
   input wire logic irq_ack,
   output logic strap_q,
   output logic irq_q
);
   // all state of this pin
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic rst_d1;
      logic strap;
      logic pend;
   } emp_irqs_type;
   emp_irqs_type st_q, st_d;

   // next state
   always_comb begin
      st_d = st_q;
      st_d.s1 = pin_n; // pin only read, never driven
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.rst_d1 = rst;
      // catch the strap on the first edge after reset leaves
      if (st_q.rst_d1 && !rst) begin
         st_d.strap = st_q.s2;
      end
      if (rst) begin
         st_d.pend = 1'b0;
      end else if (edge_mode) begin
         // falling edge latches; a new edge beats the acknowledge
         if (st_q.s3 && !st_q.s2) begin
            st_d.pend = 1'b1;
         end else if (irq_ack) begin
            st_d.pend = 1'b0;
         end
      end else begin
         st_d.pend = !st_q.s2; // level mode follows the pin
      end
   end

   // registers; synchroniser runs through reset so the strap is settled
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q.pend <= 1'b0;
         st_q.s1 <= st_d.s1;
         st_q.s2 <= st_d.s2;
         st_q.s3 <= st_d.s3;
         st_q.rst_d1 <= 1'b1;
         st_q.strap <= st_q.strap;
      end else begin
         st_q <= st_d;
      end
   end

   assign strap_q = st_q.strap;
   assign irq_q = st_q.pend; // interrupts only live after reset
endmodule

// ===== testbench/emp_mem_model.sv
// far side: small external memory plus a second bus master
// assumes emp_port pins and a bench that sets hold_n
`timescale 1ns/1ps
module emp_mem_model (
   input wire logic clk_sys,
   input wire emp_pkg::emp_pins_type pins_q,
   input wire logic hold_n,
   output logic [emp_pkg::DATA_W-1:0] data_in,
   output logic bus_request_n
);
   logic [emp_pkg::DATA_W-1:0] mem [16]; // low address bits only, keeps it tiny
   logic [emp_pkg::DATA_W-1:0] last_q = '0; // last bus level
   // store while the write strobe is driven low
   always @(posedge clk_sys) begin
      if (pins_q.ctrl_oe && !pins_q.write_n && pins_q.data_oe) begin
         mem[pins_q.addr[3:0]] <= pins_q.data;
      end
      last_q <= data_in;
   end
   // an idle bus never repeats the last value, so stale reads show up
   assign data_in = (pins_q.ctrl_oe && !pins_q.read_n) ? mem[pins_q.addr[3:0]] : ~last_q;
   assign bus_request_n = hold_n; // pulled up unless the bench asks
endmodule

// ===== testbench/emp_port_chk.sv
// checker: port pin timing against the core request
// assumes it is bound to emp_port
`timescale 1ns/1ps
module emp_port_chk (
   input wire logic clk_sys,
   input wire logic rst,
   input wire emp_pkg::emp_req_type core_req,
   input wire logic bus_request_n,
   input wire logic insn_done,
   input wire logic boot_mode_pin_a,
   input wire logic boot_mode_pin_b,
   input wire emp_pkg::emp_pins_type pins_q,
   input wire logic core_ack_q,
   input wire logic [7:0] operating_mode_register_q
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire logic arb = operating_mode_register_q[emp_pkg::ARB_BIT]; // wait/strobe option
   sequence quiet_s; pins_q.read_n && pins_q.write_n; endsequence
   sequence asked_s; (!arb && !bus_request_n && insn_done && !core_req.valid)[*4]; endsequence
   addr_hold_a: assert property (quiet_s ##1 quiet_s |-> $stable(pins_q.addr))
      else $error("address moved while idle");
   data_float_a: assert property (!arb && pins_q.grant_strobe_oe && !pins_q.grant_strobe_n
      |-> !pins_q.data_oe && !pins_q.ctrl_oe && !pins_q.addr_oe) else $error("grant on driven bus");
   prog_sel_a: assert property (!pins_q.program_space_select_n
      |-> core_req.valid && core_req.space == emp_pkg::SPACE_P) else $error("bad program select");
   data_sel_a: assert property (!pins_q.data_space_select_n |-> core_req.valid &&
      core_req.space != emp_pkg::SPACE_P &&
      pins_q.xy_select == (core_req.space == emp_pkg::SPACE_X)) else $error("bad data select");
   read_strobe_a: assert property (!pins_q.read_n
      |-> core_req.valid && !core_req.write && !pins_q.data_oe) else $error("bad read strobe");
   write_strobe_a: assert property (!pins_q.write_n |-> core_req.valid && core_req.write &&
      pins_q.data_oe && pins_q.data == core_req.wdata) else $error("bad write strobe");
   reset_float_a: assert property (disable iff (1'b0) rst
      |=> !pins_q.ctrl_oe && !pins_q.grant_strobe_oe) else $error("pins driven in reset");
   release_a: assert property (asked_s |-> !pins_q.ctrl_oe && !pins_q.addr_oe)
      else $error("port not released");
   strobe_a: assert property (arb && not_quiet() |-> !pins_q.grant_strobe_n)
      else $error("bus strobe missing");
   wait_a: assert property ((arb && !bus_request_n)[*4] |-> !core_ack_q)
      else $error("ack during wait");
   mode_latch_a: assert property ($fell(rst) |-> ##2
      operating_mode_register_q[1:0] == {boot_mode_pin_b, boot_mode_pin_a})
      else $error("mode not latched");
   function automatic logic not_quiet();
      return !(pins_q.read_n && pins_q.write_n);
   endfunction
endmodule
bind emp_port emp_port_chk chk (.clk_sys(clk_sys), .rst(rst), .core_req(core_req),
   .bus_request_n(bus_request_n), .insn_done(insn_done), .boot_mode_pin_a(boot_mode_pin_a),
   .boot_mode_pin_b(boot_mode_pin_b), .pins_q(pins_q), .core_ack_q(core_ack_q),
   .operating_mode_register_q(operating_mode_register_q));

// ===== testbench/emp_port_bench.sv
// bench: drives emp_port accesses, mode pins and arbitration
// assumes emp_mem_model answers on the external pins
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
   $display("ERROR %0t %h %h", $time, (a), (e)); end end
module emp_port_bench;
   logic clk_sys = 0, rst = 1, insn_done = 0, mode_we = 0, hold_n = 1, pa = 1, pb = 1;
   logic [7:0] mode_wdata = 8'h00, operating_mode_register;
   logic [1:0] irq_edge_mode = 2'h0, irq_ack = 2'h0;
   emp_pkg::emp_req_type core_req = '0; // held until acknowledged
   emp_pkg::emp_pins_type pins_q;
   logic [23:0] data_in, core_rdata_q, shadow [16], exp_q [$]; // notes of expected reads
   logic core_ack_q, ira, irb, bus_request_n, rd_now = 0;
   int fails = 0, checked = 0, seed = 45, n;
   always #12.5 clk_sys = ~clk_sys;
   emp_port dut (.clk_sys(clk_sys), .rst(rst), .core_req(core_req), .insn_done(insn_done),
      .mode_we(mode_we), .mode_wdata(mode_wdata), .irq_edge_mode(irq_edge_mode),
      .irq_ack(irq_ack), .data_in(data_in), .bus_request_n(bus_request_n),
      .boot_mode_pin_a(pa), .boot_mode_pin_b(pb), .pins_q(pins_q), .core_ack_q(core_ack_q),
      .core_rdata_q(core_rdata_q), .operating_mode_register_q(operating_mode_register),
      .external_request_a_q(ira), .external_request_b_q(irb));
   emp_mem_model far (.clk_sys(clk_sys), .pins_q(pins_q), .hold_n(hold_n),
      .data_in(data_in), .bus_request_n(bus_request_n));
   task automatic summarize;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge clk_sys);
      #2;
   endtask
   // one access; the bound on the wait stands in for a hang
   task automatic acc(input logic w, input logic [1:0] sp, input logic [3:0] a);
      logic [23:0] d;
      d = 24'($random(seed));
      step(1);
      core_req = '{1'b1, w, sp, {12'h000, a}, d};
      if (w) shadow[a] = d;
      else exp_q.push_back(shadow[a]);
      rd_now = !w;
      for (n = 0; n < 40 && core_ack_q !== 1'b1; n++) begin
         @(posedge clk_sys);
         #1;
      end
      if (n == 40) begin
         fails++;
         summarize();
      end
      #1;
      core_req.valid = 0;
   endtask
   task automatic setm(input logic [7:0] v);
      mode_wdata = v;
      mode_we = 1;
      step(1);
      mode_we = 0;
      step(1);
      `CHK(operating_mode_register, v)
   endtask
   // read data meets the oldest note at each read acknowledge
   always @(negedge clk_sys) if (core_ack_q === 1'b1 && rd_now) begin
      `CHK(core_rdata_q, exp_q.pop_front())
   end
   initial begin
      {pb, pa} = 2'($random(seed)); // strap held through reset
      step(6);
      `CHK(pins_q.ctrl_oe, 1'b0)
      rst = 0;
      step(3);
      `CHK(operating_mode_register[1:0], {pb, pa})
      pa = 1;
      pb = 1;
      irq_edge_mode = 2'h2; // a level, b falling edge
      step(4);
      pa = 0;
      pb = 0;
      step(1);
      pb = 1;
      step(4);
      `CHK({ira, irb}, 2'h3)
      pa = 1;
      irq_ack = 2'h3;
      step(1);
      irq_ack = 0;
      step(4);
      `CHK({ira, irb}, 2'h0)
      setm(8'h5a);
      for (int i = 0; i < 12; i++) acc(i < 6, 2'(i % 3), 4'(i % 6));
      insn_done = 1;
      hold_n = 0; // another master asks
      for (n = 0; n < 20 && pins_q.grant_strobe_n !== 1'b0; n++) step(1);
      if (n == 20) begin
         fails++;
         summarize();
      end
      `CHK({pins_q.grant_strobe_n, pins_q.ctrl_oe, pins_q.data_oe}, 3'h0)
      hold_n = 1;
      step(8);
      `CHK({pins_q.grant_strobe_n, pins_q.ctrl_oe}, 2'h3)
      setm(8'h80);
      fork
         acc(1'b0, emp_pkg::SPACE_X, 4'h1);
         begin
            hold_n = 0; // wait states stretch the read
            step(6);
            hold_n = 1;
         end
      join
      `CHK(n > 6, 1'b1)
      summarize();
   end
endmodule
